// [src/pig_pkg.sv]
/*
 * Constants, register map and carrier types of the peripheral idle gating block.
 * Assumes a 250 MHz CPU clock and an AXI4-Lite register bus with 32-bit data.
 */
package pig_pkg;

    // ------------------------------------------------------------------
    // Register map: printed word indexes, byte address is index * 4
    // ------------------------------------------------------------------
    localparam int PIG_ADDR_W = 18;
    localparam logic [15:0] PIG_IDX_CTRL = 16'h9400;
    localparam logic [15:0] PIG_IDX_STATE = 16'h9401;
    localparam logic [15:0] PIG_IDX_MASTER = 16'h9402;
    localparam logic [15:0] PIG_IDX_GLB_CTRL = 16'h9404;
    localparam logic [15:0] PIG_IDX_GLB_STATE = 16'h9405;
    localparam logic [1:0] PIG_WORD_LSB = 2'h0;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int PIG_UNITS = 14;
    localparam int PIG_MASTERS = 2;
    localparam int PIG_REG_W = 16;
    localparam logic [15:0] PIG_CTRL_MASK = 16'h3fff;
    localparam logic [15:0] PIG_MASTER_MASK = 16'h0003;
    localparam logic [15:0] PIG_GLB_MASK = 16'h0001;
    localparam logic [15:0] PIG_REG_RESET = 16'h0000;
    localparam int PIG_GLB_PERI_BIT = 0;

    // ------------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0] PIG_RESP_OKAY = 2'h0;
    localparam logic [1:0] PIG_RESP_SLVERR = 2'h2;
    localparam logic [31:0] PIG_DATA_ZERO = 32'h0000_0000;

    // One write request: address, data and byte strobes
    typedef struct packed {
        logic [PIG_ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } pig_wr_req_type;

    // Gating state of one unit
    typedef enum logic [2:0] {
        PIG_RUN = 3'b001,
        PIG_STOPPING = 3'b010,
        PIG_STOPPED = 3'b100
    } pig_gate_state_type;

endpackage

// [src/pig_axi_wr.sv]
/*
 * Write-side collector: takes write address and write data in either order
 * and offers them as one request. Assumes the consumer pulses req_take.
 */
`timescale 1ns/1ps
`default_nettype none
module pig_axi_wr (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [pig_pkg::PIG_ADDR_W-1:0] awaddr, // Write address
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write strobes
    output logic req_valid, // Both halves held
    output pig_pkg::pig_wr_req_type req, // Collected request
    input wire logic req_take // Request consumed
);
    logic aw_held_reg;
    logic w_held_reg;
    pig_pkg::pig_wr_req_type req_reg;

    assign awready = !aw_held_reg;
    assign wready = !w_held_reg;
    assign req_valid = aw_held_reg && w_held_reg;
    assign req = req_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            req_reg <= '0;
        end else begin
            if (awvalid && !aw_held_reg) begin
                aw_held_reg <= 1'b1;
                req_reg.addr <= awaddr;
            end else if (req_take) begin
                aw_held_reg <= 1'b0;
            end
            if (wvalid && !w_held_reg) begin
                w_held_reg <= 1'b1;
                req_reg.data <= wdata;
                req_reg.strb <= wstrb;
            end else if (req_take) begin
                w_held_reg <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [src/pig_unit_gate.sv]
/*
 * Gating sequencer of one on-chip unit: asks the unit to stop, waits for its
 * acknowledge, and releases it on wake. Assumes unit_stopped is on aclk.
 */
`timescale 1ns/1ps
`default_nettype none
module pig_unit_gate (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic idle_exec, // Idle instruction executes, pulse
    input wire logic enter, // Peripheral idle requested
    input wire logic gate_bit, // Per-unit gating control bit
    input wire logic unit_stopped, // Unit reports it has stopped
    output logic stop_req, // Stop request to the unit
    output logic status // Unit is disabled
);
    pig_pkg::pig_gate_state_type state_reg;
    pig_pkg::pig_gate_state_type state_next;
    logic gate_now;
    logic status_reg;

    // Idle with the flag set stops the unit only when its bit is 1
    assign gate_now = enter && gate_bit;
    assign stop_req = (state_reg != pig_pkg::PIG_RUN);
    assign status = status_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            pig_pkg::PIG_RUN: begin
                if (idle_exec && gate_now) state_next = pig_pkg::PIG_STOPPING;
            end
            pig_pkg::PIG_STOPPING: begin
                if (idle_exec && !gate_now) state_next = pig_pkg::PIG_RUN;
                else if (unit_stopped) state_next = pig_pkg::PIG_STOPPED;
            end
            pig_pkg::PIG_STOPPED: begin
                if (idle_exec && !gate_now) state_next = pig_pkg::PIG_RUN;
            end
            default: state_next = pig_pkg::PIG_RUN;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= pig_pkg::PIG_RUN;
            status_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            status_reg <= (state_next == pig_pkg::PIG_STOPPED) && unit_stopped;
        end
    end
endmodule
`default_nettype wire

// [src/pig_top.sv]
/*
 * Peripheral idle gating: per-unit idle control, idle status reporting,
 * bus-master idle control and the AXI4-Lite register slave.
 * Assumes idle_exec, unit_stopped and master_idle come from logic on aclk.
 */
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] Bit 6 set, flag set, idle executes: unit six is stopped.
// [R2] Bit 5 set, flag set, idle executes: general pin port is stopped.
// [R3] Bit 4 set, flag set, idle executes: third serial port is stopped.
// [R4] Bit 3 set, flag set, idle executes: second serial port is stopped.
// [R5] Bit 2 set, flag set, idle executes: first serial port is stopped.
// [R6] Bit 1 set, flag set, idle executes: second timer is stopped.
// [R7] Bit 0 set, flag set, idle executes: first timer is stopped.
// [R8] Control bits are read/write, reset 0; a cleared bit keeps its unit running.
// [R9] Read-only idle state register at index 0x9401; bits 15-14 read zero.
// [R10] State bit 13 shows the miscellaneous group disabled.
// [R11] State bit 12 shows the external memory interface disabled.
// [R12] State bit 11 shows the OS tick timer disabled.
// [R13] State bit 10 shows the watchdog disabled.
// [R14] State bit 9 shows the parallel pin logic disabled.
// [R15] State bit 8 shows the UART disabled.
// [R16] State bits 7 to 0 show the remaining units disabled, in order.
// [R17] Bus-master idle control register at index 0x9402.
// [R18] Idle with flag set wakes any idled unit whose bit is 0.
// [R19] Idle with request cleared wakes every unit, ignoring gating bits.
// [R20] A state bit sets only after its unit stops and clears on resume.
// [R21] Writes to reserved or read-only bits have no effect.
module pig_top (
    input wire logic aclk, // Clock, 250 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [pig_pkg::PIG_ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic [2:0] s_axi_awprot, // Write protection, unused
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    output logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    input wire logic [pig_pkg::PIG_ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic [2:0] s_axi_arprot, // Read protection, unused
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    input wire logic idle_exec, // Idle instruction executes, pulse
    input wire logic [pig_pkg::PIG_UNITS-1:0] unit_stopped, // Units report stopped
    output logic [pig_pkg::PIG_UNITS-1:0] unit_stop_req, // Stop requests to units
    input wire logic master_idle, // Bus-master idle state is active
    output logic [pig_pkg::PIG_MASTERS-1:0] bus_master_gate, // Bus-master disables
    output logic peripheral_sleep_flag // Global peripheral idle flag
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [pig_pkg::PIG_REG_W-1:0] periph_idle_ctrl_reg;
    logic [pig_pkg::PIG_REG_W-1:0] periph_idle_ctrl_next;
    logic [pig_pkg::PIG_REG_W-1:0] bus_master_idle_ctrl_reg;
    logic [pig_pkg::PIG_REG_W-1:0] bus_master_idle_ctrl_next;
    logic [pig_pkg::PIG_REG_W-1:0] global_idle_ctrl_reg;
    logic [pig_pkg::PIG_REG_W-1:0] global_idle_ctrl_next;
    logic sleep_flag_reg;
    logic [pig_pkg::PIG_UNITS-1:0] unit_status;
    logic [pig_pkg::PIG_REG_W-1:0] periph_idle_state;
    logic [pig_pkg::PIG_REG_W-1:0] global_idle_state;
    logic peri_req;

    logic wr_valid;
    pig_pkg::pig_wr_req_type wr_req;
    logic wr_take;
    logic [15:0] wr_index;
    logic wr_aligned;
    logic wr_hit_ctrl;
    logic wr_hit_state;
    logic wr_hit_master;
    logic wr_hit_glb_ctrl;
    logic wr_hit_glb_state;
    logic wr_mapped;
    logic [pig_pkg::PIG_REG_W-1:0] wr_lanes;
    logic [pig_pkg::PIG_REG_W-1:0] wr_data16;
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    logic rd_take;
    logic [15:0] rd_index;
    logic rd_aligned;
    logic rd_hit_ctrl;
    logic rd_hit_state;
    logic rd_hit_master;
    logic rd_hit_glb_ctrl;
    logic rd_hit_glb_state;
    logic rd_mapped;
    logic [pig_pkg::PIG_REG_W-1:0] rd_word;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // ------------------------------------------------------------------
    // Write channel collection
    // ------------------------------------------------------------------
    pig_axi_wr u_wr (
        .aclk(aclk),
        .aresetn(aresetn),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .awaddr(s_axi_awaddr),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .req_valid(wr_valid),
        .req(wr_req),
        .req_take(wr_take)
    );

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    assign wr_take = wr_valid && !bvalid_reg;
    assign wr_index = wr_req.addr[pig_pkg::PIG_ADDR_W-1:2];
    assign wr_aligned = (wr_req.addr[1:0] == pig_pkg::PIG_WORD_LSB);
    assign wr_hit_ctrl = wr_aligned && (wr_index == pig_pkg::PIG_IDX_CTRL);
    assign wr_hit_state = wr_aligned && (wr_index == pig_pkg::PIG_IDX_STATE);
    assign wr_hit_master = wr_aligned && (wr_index == pig_pkg::PIG_IDX_MASTER);
    assign wr_hit_glb_ctrl = wr_aligned && (wr_index == pig_pkg::PIG_IDX_GLB_CTRL);
    assign wr_hit_glb_state = wr_aligned && (wr_index == pig_pkg::PIG_IDX_GLB_STATE);
    assign wr_mapped = wr_hit_ctrl || wr_hit_state || wr_hit_master || wr_hit_glb_ctrl || wr_hit_glb_state;

    // Byte strobes select which half of the 16-bit register is written
    assign wr_lanes = {{8{wr_req.strb[1]}}, {8{wr_req.strb[0]}}};
    assign wr_data16 = wr_req.data[pig_pkg::PIG_REG_W-1:0];

    // Only writable bits take data; reserved bits stay zero
    assign periph_idle_ctrl_next = (wr_take && wr_hit_ctrl)
        ? ((periph_idle_ctrl_reg & ~wr_lanes) | (wr_data16 & wr_lanes)) & pig_pkg::PIG_CTRL_MASK // [R8] [R21]
        : periph_idle_ctrl_reg;
    assign bus_master_idle_ctrl_next = (wr_take && wr_hit_master)
        ? ((bus_master_idle_ctrl_reg & ~wr_lanes) | (wr_data16 & wr_lanes)) & pig_pkg::PIG_MASTER_MASK // [R17] [R21]
        : bus_master_idle_ctrl_reg;
    assign global_idle_ctrl_next = (wr_take && wr_hit_glb_ctrl)
        ? ((global_idle_ctrl_reg & ~wr_lanes) | (wr_data16 & wr_lanes)) & pig_pkg::PIG_GLB_MASK
        : global_idle_ctrl_reg;

    // ------------------------------------------------------------------
    // Control registers and write response
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periph_idle_ctrl_reg <= pig_pkg::PIG_REG_RESET; // [R8]
            bus_master_idle_ctrl_reg <= pig_pkg::PIG_REG_RESET;
            global_idle_ctrl_reg <= pig_pkg::PIG_REG_RESET;
        end else begin
            periph_idle_ctrl_reg <= periph_idle_ctrl_next;
            bus_master_idle_ctrl_reg <= bus_master_idle_ctrl_next;
            global_idle_ctrl_reg <= global_idle_ctrl_next;
        end
    end

    // Writes to the state registers are accepted and dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= pig_pkg::PIG_RESP_OKAY;
        end else if (wr_take) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? pig_pkg::PIG_RESP_OKAY : pig_pkg::PIG_RESP_SLVERR; // [R21]
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ------------------------------------------------------------------
    // Global peripheral idle flag
    // ------------------------------------------------------------------
    assign peri_req = global_idle_ctrl_reg[pig_pkg::PIG_GLB_PERI_BIT];

    // Idle with the request cleared leaves the peripheral idle state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_flag_reg <= 1'b0;
        end else if (idle_exec) begin
            sleep_flag_reg <= peri_req; // [R19]
        end
    end

    assign peripheral_sleep_flag = sleep_flag_reg;

    // ------------------------------------------------------------------
    // Per-unit gating
    // ------------------------------------------------------------------
    // Bit n of the control register gates unit n; bits 6..0 cover unit six,
    // the pin port, the three serial ports and the two timers.
    generate
        for (genvar u = 0; u < pig_pkg::PIG_UNITS; u++) begin : g_unit
            pig_unit_gate u_gate (
                .aclk(aclk),
                .aresetn(aresetn),
                .idle_exec(idle_exec),
                .enter(peri_req), // [R18] [R19]
                .gate_bit(periph_idle_ctrl_reg[u]), // [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R8]
                .unit_stopped(unit_stopped[u]),
                .stop_req(unit_stop_req[u]),
                .status(unit_status[u]) // [R20]
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Bus-master gating
    // ------------------------------------------------------------------
    // A master is disabled while its bit is set and master idle is active
    assign bus_master_gate = bus_master_idle_ctrl_reg[pig_pkg::PIG_MASTERS-1:0]
        & {pig_pkg::PIG_MASTERS{master_idle}}; // [R17]

    // ------------------------------------------------------------------
    // State views
    // ------------------------------------------------------------------
    // Bits 13..0 follow the unit order of the control register
    assign periph_idle_state = {{(pig_pkg::PIG_REG_W - pig_pkg::PIG_UNITS){1'b0}}, unit_status}; // [R9] [R10] [R11] [R12] [R13] [R14] [R15] [R16]
    assign global_idle_state = {{(pig_pkg::PIG_REG_W - 1){1'b0}}, sleep_flag_reg};

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    assign s_axi_arready = !rvalid_reg;
    assign rd_take = s_axi_arvalid && !rvalid_reg;
    assign rd_index = s_axi_araddr[pig_pkg::PIG_ADDR_W-1:2];
    assign rd_aligned = (s_axi_araddr[1:0] == pig_pkg::PIG_WORD_LSB);
    assign rd_hit_ctrl = rd_aligned && (rd_index == pig_pkg::PIG_IDX_CTRL);
    assign rd_hit_state = rd_aligned && (rd_index == pig_pkg::PIG_IDX_STATE); // [R9]
    assign rd_hit_master = rd_aligned && (rd_index == pig_pkg::PIG_IDX_MASTER); // [R17]
    assign rd_hit_glb_ctrl = rd_aligned && (rd_index == pig_pkg::PIG_IDX_GLB_CTRL);
    assign rd_hit_glb_state = rd_aligned && (rd_index == pig_pkg::PIG_IDX_GLB_STATE);
    assign rd_mapped = rd_hit_ctrl || rd_hit_state || rd_hit_master || rd_hit_glb_ctrl || rd_hit_glb_state;

    assign rd_word = ({pig_pkg::PIG_REG_W{rd_hit_ctrl}} & periph_idle_ctrl_reg)
        | ({pig_pkg::PIG_REG_W{rd_hit_state}} & periph_idle_state)
        | ({pig_pkg::PIG_REG_W{rd_hit_master}} & bus_master_idle_ctrl_reg)
        | ({pig_pkg::PIG_REG_W{rd_hit_glb_ctrl}} & global_idle_ctrl_reg)
        | ({pig_pkg::PIG_REG_W{rd_hit_glb_state}} & global_idle_state);

    // ------------------------------------------------------------------
    // Read response
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= pig_pkg::PIG_DATA_ZERO;
            rresp_reg <= pig_pkg::PIG_RESP_OKAY;
        end else if (rd_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {{(32 - pig_pkg::PIG_REG_W){1'b0}}, rd_word};
            rresp_reg <= rd_mapped ? pig_pkg::PIG_RESP_OKAY : pig_pkg::PIG_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

endmodule
`default_nettype wire

// [verification/pig_top_assertions.sv]
/*
 * Checker of the idle gating block: gating order and read answers.
 * Assumes it is bound to pig_top and sees its ports only.
 */
`timescale 1ns/1ps
`default_nettype none
module pig_top_chk (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic idle_exec, // Idle pulse
    input wire logic [pig_pkg::PIG_UNITS-1:0] unit_stop_req, // Stop requests
    input wire logic peripheral_sleep_flag, // Global flag
    input wire logic master_idle, // Master idle state
    input wire logic [pig_pkg::PIG_MASTERS-1:0] bus_master_gate, // Master disables
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic [1:0] s_axi_rresp // Read response
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_wake_all: assert property (idle_exec ##1 !peripheral_sleep_flag |-> unit_stop_req == '0)
        else $error("stop request left after wake");
    a_gate_hold: assert property (!idle_exec |=> $stable(unit_stop_req))
        else $error("stop request moved without idle");
    a_flag_hold: assert property (!idle_exec |=> $stable(peripheral_sleep_flag))
        else $error("flag moved without idle");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_rsvd_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:14] == '0)
        else $error("reserved bits set");
    a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == pig_pkg::PIG_RESP_SLVERR
        |-> s_axi_rdata == pig_pkg::PIG_DATA_ZERO)
        else $error("error read carries data");
    a_master_gate: assert property (!master_idle |-> bus_master_gate == '0)
        else $error("master gated outside idle");

    c_sleep: cover property (idle_exec ##1 peripheral_sleep_flag);
    c_err: cover property (s_axi_rvalid && s_axi_rresp == pig_pkg::PIG_RESP_SLVERR);
    c_master: cover property (master_idle && bus_master_gate != '0);
endmodule

bind pig_top pig_top_chk u_chk (.aclk(aclk), .aresetn(aresetn), .idle_exec(idle_exec),
    .unit_stop_req(unit_stop_req), .peripheral_sleep_flag(peripheral_sleep_flag),
    .master_idle(master_idle), .bus_master_gate(bus_master_gate), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
`default_nettype wire

// [verification/pig_unit_model.sv]
/*
 * Gated units: even units stop one cycle after the request, odd ones two.
 * Stall keeps every unit running. Assumes requests come on aclk.
 */
`timescale 1ns/1ps
`default_nettype none
module pig_unit_model (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic stall, // Hold units running
    input wire logic [pig_pkg::PIG_UNITS-1:0] stop_req, // Stop requests
    output logic [pig_pkg::PIG_UNITS-1:0] stopped // Units stopped
);
    localparam logic [13:0] FAST = 14'h1555;
    logic [13:0] req_reg;
    wire logic [13:0] stopped_next = stop_req & ~{14{stall}} & (FAST | req_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_reg <= '0;
            stopped <= '0;
        end else begin
            req_reg <= stop_req;
            stopped <= stopped_next;
        end
    end
endmodule
`default_nettype wire

// [verification/test_peripheral_idle_gating.sv]
/*
 * Bench of the idle gating block: register access over AXI4-Lite and
 * idle entry and wake with a model of the gated units.
 */
`timescale 1ns/1ps
`default_nettype none
module test_peripheral_idle_gating;
    localparam logic [17:0] A_CTRL = {pig_pkg::PIG_IDX_CTRL, pig_pkg::PIG_WORD_LSB};
    localparam logic [17:0] A_STATE = {pig_pkg::PIG_IDX_STATE, pig_pkg::PIG_WORD_LSB};
    localparam logic [17:0] A_MAST = {pig_pkg::PIG_IDX_MASTER, pig_pkg::PIG_WORD_LSB};
    localparam logic [17:0] A_GLB = {pig_pkg::PIG_IDX_GLB_CTRL, pig_pkg::PIG_WORD_LSB};
    localparam logic [17:0] A_GST = {pig_pkg::PIG_IDX_GLB_STATE, pig_pkg::PIG_WORD_LSB};
    localparam logic [1:0] OK = pig_pkg::PIG_RESP_OKAY;
    localparam logic [1:0] ERR = pig_pkg::PIG_RESP_SLVERR;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic idle_exec = 0, master_idle = 0, stall = 0;
    logic [17:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    wire logic awr, wr_rdy, bv, arr, rv, flag;
    wire logic [1:0] bresp, rresp, gate;
    wire logic [31:0] rdata;
    wire logic [13:0] stopped, stop_req;
    int n_fail = 0, comparisons = 0;

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

    always #2 aclk = ~aclk;

    pig_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bv), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .idle_exec(idle_exec), .unit_stopped(stopped), .unit_stop_req(stop_req),
        .master_idle(master_idle), .bus_master_gate(gate), .peripheral_sleep_flag(flag));
    pig_unit_model u_units (.aclk(aclk), .aresetn(aresetn), .stall(stall), .stop_req(stop_req),
        .stopped(stopped));

    task automatic complete_run;
        $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int i;
        logic aw_hs, w_hs, b_hs;
        logic [1:0] resp;
        b_hs = 1'b0;
        resp = 2'h0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awv <= 1;
        wv <= 1;
        bready <= 1;
        // Handshakes are judged on settled values ahead of the edge that takes them
        for (i = 0; i < 40 && !b_hs; i++) begin
            @(negedge aclk);
            aw_hs = awv && awr;
            w_hs = wv && wr_rdy;
            b_hs = bv;
            resp = bresp;
            @(posedge aclk);
            if (aw_hs) awv <= 0;
            if (w_hs) wv <= 0;
        end
        bready <= 0;
        if (!b_hs) begin
            n_fail++;
            complete_run();
        end
        `CHK(resp, er)
        @(posedge aclk);
    endtask

    task automatic rd(input logic [17:0] a, input logic [31:0] e, input logic [1:0] er);
        int i;
        logic ar_hs, r_hs;
        logic [31:0] data;
        logic [1:0] resp;
        r_hs = 1'b0;
        data = 32'h0000_0000;
        resp = 2'h0;
        araddr <= a;
        arv <= 1;
        rready <= 1;
        for (i = 0; i < 40 && !r_hs; i++) begin
            @(negedge aclk);
            ar_hs = arv && arr;
            r_hs = rv;
            data = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ar_hs) arv <= 0;
        end
        rready <= 0;
        if (!r_hs) begin
            n_fail++;
            complete_run();
        end
        `CHK(data, e)
        `CHK(resp, er)
        @(posedge aclk);
    endtask

    task automatic idle(input logic [13:0] er, input logic ef);
        idle_exec <= 1;
        @(posedge aclk);
        idle_exec <= 0;
        @(posedge aclk);
        #1;
        `CHK(stop_req, er)
        `CHK(flag, ef)
        repeat (4) @(posedge aclk);
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(A_CTRL, 32'h0000_0000, OK);
        rd(A_STATE, 32'h0000_0000, OK);
        rd(A_MAST, 32'h0000_0000, OK);
        rd(18'h0_0040, 32'h0000_0000, ERR);
        wr(A_CTRL + 18'h0_0002, 32'hffff_ffff, 4'hf, ERR);
        wr(A_CTRL, 32'hffff_ffff, 4'h1, OK);
        rd(A_CTRL, 32'h0000_00ff, OK);
        wr(A_CTRL, 32'hffff_ffff, 4'hf, OK);
        rd(A_CTRL, 32'h0000_3fff, OK);
        wr(A_STATE, 32'hffff_ffff, 4'hf, OK);
        rd(A_STATE, 32'h0000_0000, OK);
        wr(A_MAST, 32'hffff_ffff, 4'hf, OK);
        rd(A_MAST, 32'h0000_0003, OK);
        master_idle <= 1;
        @(posedge aclk);
        #1;
        `CHK(gate, 2'h3)
        @(posedge aclk);
        master_idle <= 0;
        wr(A_CTRL, 32'h0000_007f, 4'hf, OK);
        wr(A_GLB, 32'h0000_0001, 4'hf, OK);
        stall <= 1;
        idle(14'h007f, 1'b1);
        rd(A_STATE, 32'h0000_0000, OK);
        stall <= 0;
        repeat (4) @(posedge aclk);
        rd(A_STATE, 32'h0000_007f, OK);
        wr(A_CTRL, 32'h0000_3f80, 4'hf, OK);
        idle(14'h3f80, 1'b1);
        rd(A_STATE, 32'h0000_3f80, OK);
        rd(A_GST, 32'h0000_0001, OK);
        wr(A_GLB, 32'h0000_0000, 4'hf, OK);
        idle(14'h0000, 1'b0);
        rd(A_STATE, 32'h0000_0000, OK);
        rd(A_GST, 32'h0000_0000, OK);
        rd(A_CTRL, 32'h0000_3f80, OK);
        complete_run();
    end
endmodule
`default_nettype wire
